// ===== design/swpmc_ctl_if.sv
/*
 Interface between the power mode controller and its idle timer and pulse generator.
 Assumes all three modules share i_sys_clk.
*/
`timescale 1ns/100ps
interface swpmc_ctl_if;
	logic ed_run;
	logic energy_any;
	logic [7:0] idle_timeout;
	logic go_sleep;
	logic pulse_run;
	logic pulse;

	modport ctl (output ed_run, output energy_any, output idle_timeout, output pulse_run,
		input go_sleep, input pulse);
	modport idle (input ed_run, input energy_any, input idle_timeout, output go_sleep);
	modport pls (input pulse_run, output pulse);
endinterface

// ===== design/swpmc_idle_timer.sv
/*
 Idle timer for energy detect mode: counts time units without cable energy.
 Assumes energy_any is already synchronised to i_sys_clk.
*/
`timescale 1ns/100ps
module swpmc_idle_timer #(
	parameter int UNIT_CYC = swpmc_pkg::IDLE_UNIT_CYC
)(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	swpmc_ctl_if.idle bus
);
	logic [31:0] tick_reg;
	logic [8:0] units_reg;
	logic go_sleep_reg;

	// ----------------------------------------
	// Unit counter
	// ----------------------------------------
	// Any energy restarts the count, so only a continuous idle span can sleep
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst || !bus.ed_run || bus.energy_any)
		begin
			tick_reg <= 32'h0000_0000;
			units_reg <= 9'h000;
		end
		else if (tick_reg == 32'(UNIT_CYC - 1))
		begin
			tick_reg <= 32'h0000_0000;
			if (units_reg != 9'h1ff)
				units_reg <= units_reg + 9'h001;
		end
		else
			tick_reg <= tick_reg + 32'h0000_0001;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst || !bus.ed_run || bus.energy_any)
			go_sleep_reg <= 1'b0;
		else
			go_sleep_reg <= units_reg > {1'b0, bus.idle_timeout};
	end

	assign bus.go_sleep = go_sleep_reg;

	a_idle_sleep: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(bus.ed_run && !bus.energy_any && units_reg > {1'b0, bus.idle_timeout})
		|=> (go_sleep_reg || bus.energy_any || !bus.ed_run))
		else $error("idle timer did not raise sleep after timeout");
endmodule

// ===== design/swpmc_pkg.sv
/*
 Constants, offsets, reset values and state codes for the switch power mode controller.
 Assumes a 100 MHz system clock and a host that reaches the registers over a plain port.
*/
package swpmc_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] REG_POWER_MODE = 8'h0e;
	localparam logic [7:0] REG_SLEEP_IDLE = 8'h0f;
	localparam logic [7:0] REG_PORT_CTRL_BASE = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h20;
	localparam int MODE_LSB = 3;
	localparam int PORT_PDN_BIT = 3;
	localparam logic [7:0] POWER_MODE_RST = 8'h00;
	localparam logic [7:0] SLEEP_IDLE_RST = 8'h50;
	localparam logic [7:0] PORT_CTRL_RST = 8'h00;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int PULSE_WIDTH_NS = 120;
	localparam int PULSE_WIDTH_CYC = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_PERIOD_MS = 1000;
	localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_MS * (1000000 / CLK_PERIOD_NS);
	localparam int IDLE_UNIT_US = 1000;
	localparam int IDLE_UNIT_CYC = IDLE_UNIT_US * (1000 / CLK_PERIOD_NS);

	// ----------------------------------------
	// Modes and states
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		MODE_NORMAL = 2'b00,
		MODE_ENERGY = 2'b01,
		MODE_SOFT_PD = 2'b10,
		MODE_SAVING = 2'b11
	} swpmc_mode_t;

	typedef enum logic [2:0]
	{
		ST_NORMAL = 3'b000,
		ST_ED_AWAKE = 3'b001,
		ST_ED_SLEEP = 3'b010,
		ST_SOFT_PD = 3'b011,
		ST_SAVING = 3'b100
	} swpmc_state_t;
endpackage

// ===== design/swpmc_pulse_gen.sv
/*
 Link pulse generator for energy detect mode with no cable: one short pulse per period.
 Assumes pulse_run comes from logic on i_sys_clk.
*/
`timescale 1ns/100ps
module swpmc_pulse_gen #(
	parameter int PERIOD_CYC = swpmc_pkg::PULSE_PERIOD_CYC
)(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	swpmc_ctl_if.pls bus
);
	logic [31:0] cnt_reg;
	logic pulse_reg;
	logic [7:0] high_cnt_reg;

	// ----------------------------------------
	// Period counter and pulse
	// ----------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst || !bus.pulse_run || cnt_reg == 32'(PERIOD_CYC - 1))
			cnt_reg <= 32'h0000_0000;
		else
			cnt_reg <= cnt_reg + 32'h0000_0001;
	end

	// A pulse that has started ends early if energy returns, since pulse_run then drops
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			pulse_reg <= 1'b0;
		else if (bus.pulse_run && cnt_reg == 32'h0000_0000)
			pulse_reg <= 1'b1;
		else if (cnt_reg == 32'(swpmc_pkg::PULSE_WIDTH_CYC) || !bus.pulse_run)
			pulse_reg <= 1'b0;
	end

	assign bus.pulse = pulse_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Width is counted here so the check needs no long repetition
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst || !pulse_reg)
			high_cnt_reg <= 8'h00;
		else if (high_cnt_reg != 8'hff)
			high_cnt_reg <= high_cnt_reg + 8'h01;
	end

	a_pulse_width: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(pulse_reg && bus.pulse_run && high_cnt_reg < 8'(swpmc_pkg::PULSE_WIDTH_CYC - 1))
		|=> pulse_reg)
		else $error("energy detect pulse ended early");
	a_pulse_end: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(pulse_reg && high_cnt_reg == 8'(swpmc_pkg::PULSE_WIDTH_CYC - 1)) |=> !pulse_reg)
		else $error("energy detect pulse ran past its width");
endmodule

// ===== design/swpmc_top.sv
/*
 Switch power mode controller: mode register, power state machine, block enables.
 Assumes the host uses one-cycle read and write strobes on i_sys_clk, and that
 cable energy arrives asynchronously from the PHY receivers.
*/
`timescale 1ns/100ps
module swpmc_top #(
	parameter int PORTS = 2,
	parameter int IDLE_UNIT_CYC = swpmc_pkg::IDLE_UNIT_CYC,
	parameter int PULSE_PERIOD_CYC = swpmc_pkg::PULSE_PERIOD_CYC
)(
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	input wire logic [PORTS-1:0] i_cable_energy,
	input wire logic [PORTS-1:0] i_an_enable,
	input wire logic [PORTS-1:0] i_phy_pdn,
	output logic [7:0] o_rd_data,
	output logic o_clk_gen_en,
	output logic o_mac_en,
	output logic o_host_if_en,
	output logic [PORTS-1:0] o_phy_tx_en,
	output logic [PORTS-1:0] o_phy_rx_en,
	output logic [PORTS-1:0] o_phy_ed_en,
	output logic o_ed_pulse,
	output logic o_internal_reset
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	swpmc_ctl_if ctl ();
	logic rst_int;
	logic wake_reg;
	logic [PORTS-1:0] energy_meta_reg;
	logic [PORTS-1:0] energy_sync_reg;
	logic [7:0] power_mode_reg;
	logic [7:0] sleep_idle_reg;
	logic [7:0] port_ctrl_reg [PORTS];
	logic [PORTS-1:0] pdn;
	logic [PORTS-1:0] saving_port;
	logic [1:0] mode_field;
	logic host_ok;
	logic access;
	swpmc_pkg::swpmc_state_t state_reg;
	swpmc_pkg::swpmc_state_t state_next;

	function automatic logic run_state(input swpmc_pkg::swpmc_state_t s);
		return s == swpmc_pkg::ST_NORMAL || s == swpmc_pkg::ST_SAVING
			|| s == swpmc_pkg::ST_ED_AWAKE;
	endfunction

	// ----------------------------------------
	// Reset and wake
	// ----------------------------------------
	// Internal reset reuses the hardware reset path; wake_reg, o_internal_reset and the synchroniser do not see it
	assign rst_int = i_reset || wake_reg;
	assign access = i_wr_stb || i_rd_stb;
	assign host_ok = run_state(state_reg);

	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
			wake_reg <= 1'b0;
		else
			wake_reg <= access && state_reg == swpmc_pkg::ST_SOFT_PD;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
			o_internal_reset <= 1'b0;
		else
			o_internal_reset <= wake_reg;
	end

	// ----------------------------------------
	// Energy synchroniser
	// ----------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		energy_meta_reg <= i_cable_energy;
		energy_sync_reg <= energy_meta_reg;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// The wake access is a dummy: it is neither stored nor answered
	always_ff @(posedge i_sys_clk)
	begin
		if (rst_int)
		begin
			power_mode_reg <= swpmc_pkg::POWER_MODE_RST;
			sleep_idle_reg <= swpmc_pkg::SLEEP_IDLE_RST;
		end
		else if (i_wr_stb && host_ok)
		begin
			if (i_addr == swpmc_pkg::REG_POWER_MODE)
				power_mode_reg <= i_wr_data;
			if (i_addr == swpmc_pkg::REG_SLEEP_IDLE)
				sleep_idle_reg <= i_wr_data;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		for (int p = 0; p < PORTS; p++)
		begin
			if (rst_int)
				port_ctrl_reg[p] <= swpmc_pkg::PORT_CTRL_RST;
			else if (i_wr_stb && host_ok && i_addr == swpmc_pkg::REG_PORT_CTRL_BASE + 8'(p))
				port_ctrl_reg[p] <= i_wr_data;
		end
	end

	function automatic logic [7:0] read_mux(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == swpmc_pkg::REG_POWER_MODE)
			v = power_mode_reg;
		else if (a == swpmc_pkg::REG_SLEEP_IDLE)
			v = sleep_idle_reg;
		else if (a == swpmc_pkg::REG_STATUS)
			v = {state_reg, |saving_port, 2'b00, |energy_sync_reg, ctl.go_sleep};
		for (int p = 0; p < PORTS; p++)
			if (a == swpmc_pkg::REG_PORT_CTRL_BASE + 8'(p))
				v = port_ctrl_reg[p];
		return v;
	endfunction

	always_ff @(posedge i_sys_clk)
	begin
		if (rst_int)
			o_rd_data <= 8'h00;
		else if (i_rd_stb && host_ok)
			o_rd_data <= read_mux(i_addr);
		else
			o_rd_data <= 8'h00;
	end

	// ----------------------------------------
	// Power state machine
	// ----------------------------------------
	// State follows the stored field, so a mode write reaches the state two cycles after the write strobe
	assign mode_field = power_mode_reg[swpmc_pkg::MODE_LSB +: 2];

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			swpmc_pkg::ST_NORMAL, swpmc_pkg::ST_SAVING, swpmc_pkg::ST_ED_AWAKE:
			begin
				unique case (mode_field)
					swpmc_pkg::MODE_NORMAL: state_next = swpmc_pkg::ST_NORMAL;
					swpmc_pkg::MODE_ENERGY: state_next = swpmc_pkg::ST_ED_AWAKE;
					swpmc_pkg::MODE_SOFT_PD: state_next = swpmc_pkg::ST_SOFT_PD;
					swpmc_pkg::MODE_SAVING: state_next = swpmc_pkg::ST_SAVING;
				endcase
				if (state_reg == swpmc_pkg::ST_ED_AWAKE && mode_field == 2'b01 && ctl.go_sleep)
					state_next = swpmc_pkg::ST_ED_SLEEP;
			end
			swpmc_pkg::ST_ED_SLEEP:
				if (|energy_sync_reg)
					state_next = swpmc_pkg::ST_ED_AWAKE;
			swpmc_pkg::ST_SOFT_PD:
				state_next = swpmc_pkg::ST_SOFT_PD;
			default:
				state_next = swpmc_pkg::ST_NORMAL;
		endcase
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (rst_int)
			state_reg <= swpmc_pkg::ST_NORMAL;
		else
			state_reg <= state_next;
	end

	// ----------------------------------------
	// Block enables
	// ----------------------------------------
	always_comb
	begin
		for (int p = 0; p < PORTS; p++)
		begin
			pdn[p] = port_ctrl_reg[p][swpmc_pkg::PORT_PDN_BIT] || i_phy_pdn[p];
			saving_port[p] = state_reg == swpmc_pkg::ST_SAVING && i_an_enable[p]
				&& !energy_sync_reg[p];
		end
	end

	// Outputs use state_next so they line up with state_reg
	always_ff @(posedge i_sys_clk)
	begin
		if (rst_int)
		begin
			o_clk_gen_en <= 1'b1;
			o_mac_en <= 1'b1;
			o_host_if_en <= 1'b1;
			o_phy_tx_en <= '1;
			o_phy_rx_en <= '1;
			o_phy_ed_en <= '0;
		end
		else
		begin
			o_clk_gen_en <= run_state(state_next);
			o_mac_en <= run_state(state_next);
			o_host_if_en <= run_state(state_next);
			for (int p = 0; p < PORTS; p++)
			begin
				o_phy_tx_en[p] <= run_state(state_next) && !pdn[p];
				o_phy_rx_en[p] <= run_state(state_next) && !pdn[p]
					&& !(state_next == swpmc_pkg::ST_SAVING && i_an_enable[p]
					&& !energy_sync_reg[p]);
				o_phy_ed_en[p] <= state_next == swpmc_pkg::ST_ED_SLEEP && !pdn[p];
			end
		end
	end

	// ----------------------------------------
	// Idle timer and pulse generator
	// ----------------------------------------
	assign ctl.ed_run = state_reg == swpmc_pkg::ST_ED_AWAKE;
	assign ctl.energy_any = |energy_sync_reg;
	assign ctl.idle_timeout = sleep_idle_reg;
	assign ctl.pulse_run = (state_reg == swpmc_pkg::ST_ED_AWAKE
		|| state_reg == swpmc_pkg::ST_ED_SLEEP) && !ctl.energy_any;

	swpmc_idle_timer #(.UNIT_CYC(IDLE_UNIT_CYC)) u_idle (
		.i_sys_clk(i_sys_clk),
		.i_rst(rst_int),
		.bus(ctl)
	);

	swpmc_pulse_gen #(.PERIOD_CYC(PULSE_PERIOD_CYC)) u_pulse (
		.i_sys_clk(i_sys_clk),
		.i_rst(rst_int),
		.bus(ctl)
	);

	always_ff @(posedge i_sys_clk)
	begin
		if (rst_int)
			o_ed_pulse <= 1'b0;
		else
			o_ed_pulse <= ctl.pulse;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);

	a_wake_defaults: assert property (wake_reg |=>
		state_reg == swpmc_pkg::ST_NORMAL && power_mode_reg == swpmc_pkg::POWER_MODE_RST)
		else $error("soft power-down wake did not restore defaults");
	a_normal_on: assert property (state_reg == swpmc_pkg::ST_NORMAL
		|-> o_clk_gen_en && o_mac_en && o_host_if_en)
		else $error("normal mode has a block gated");
	a_write_delay: assert property ((i_wr_stb && host_ok && !wake_reg
		&& state_reg == swpmc_pkg::ST_NORMAL && mode_field == 2'b00
		&& i_addr == swpmc_pkg::REG_POWER_MODE
		&& i_wr_data[4:3] == 2'b10)
		|=> state_reg == swpmc_pkg::ST_NORMAL ##1 state_reg == swpmc_pkg::ST_SOFT_PD)
		else $error("soft power-down did not follow the mode write by two cycles");
	a_softpd_off: assert property (state_reg == swpmc_pkg::ST_SOFT_PD
		|-> !o_clk_gen_en && !o_mac_en && o_phy_tx_en == '0 && o_phy_rx_en == '0)
		else $error("soft power-down left a block powered");
	a_sleep_wake: assert property ((state_reg == swpmc_pkg::ST_ED_SLEEP
		&& |energy_sync_reg && !wake_reg) |=> state_reg == swpmc_pkg::ST_ED_AWAKE)
		else $error("energy did not wake the sleep state");
	a_sleep_gate: assert property (state_reg == swpmc_pkg::ST_ED_SLEEP
		|-> !o_host_if_en && !o_clk_gen_en && !o_mac_en && o_phy_tx_en == '0)
		else $error("sleep state left a block enabled");
	a_port_pdn: assert property ((state_next == swpmc_pkg::ST_NORMAL && pdn[0]
		&& !rst_int) |=> !o_phy_tx_en[0] && !o_phy_rx_en[0])
		else $error("port power-down did not gate the PHY");
	a_saving_keep: assert property (state_reg == swpmc_pkg::ST_SAVING
		|-> o_clk_gen_en && o_host_if_en && o_mac_en)
		else $error("saving mode gated clocks, MAC or host");
endmodule

// ===== tb/swpmc_host_model.sv
/*
 Host model for the power mode controller: one-cycle register strobes.
 Assumes the bench supplies the clock and calls the tasks after reset.
*/
`timescale 1ns/100ps
module swpmc_host_model (
	input wire logic i_sys_clk,
	input wire logic [7:0] i_rd_data,
	output logic [7:0] o_addr,
	output logic [7:0] o_wr_data,
	output logic o_wr_stb,
	output logic o_rd_stb
);
	initial
	begin
		o_addr = 8'h00;
		o_wr_data = 8'h00;
		o_wr_stb = 1'b0;
		o_rd_stb = 1'b0;
	end

	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	task automatic host_write(input logic [7:0] a, input logic [7:0] d);
	begin
		@(posedge i_sys_clk);
		o_addr <= a;
		o_wr_data <= d;
		o_wr_stb <= 1'b1;
		@(posedge i_sys_clk);
		o_wr_stb <= 1'b0;
		// Released data is inverted so a stale value cannot pass
		o_wr_data <= ~d;
	end
	endtask

	// In soft power-down the first access is a dummy, its data is thrown away
	task automatic host_read(input logic [7:0] a, output logic [7:0] d);
	begin
		@(posedge i_sys_clk);
		o_addr <= a;
		o_rd_stb <= 1'b1;
		@(posedge i_sys_clk);
		o_rd_stb <= 1'b0;
		#1;
		d = i_rd_data;
	end
	endtask
endmodule

// ===== tb/test_switch_power_mode_control.sv
/*
 Self-checking bench for the switch power mode controller.
 Assumes short idle unit and pulse period parameters to keep the run brief.
*/
`timescale 1ns/100ps
`define CHK(got, exp) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) \
		begin \
			bad_count++; \
			$display("wrong value at %0t: got %h expected %h", $time, got, exp); \
		end \
	end
module test_switch_power_mode_control;
	logic i_sys_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [7:0] addr;
	logic [7:0] wdat;
	logic wstb;
	logic rstb;
	logic [1:0] energy = 2'b00;
	logic [1:0] an_en = 2'b00;
	logic [1:0] pdn = 2'b00;
	logic [7:0] rdat;
	logic clk_en, mac_en, host_en, ed_pulse, int_rst;
	logic [1:0] tx_en, rx_en, ed_en;
	logic [7:0] rd;
	int bad_count = 0;
	int tests_run = 0;
	int n;

	always #5 i_sys_clk = ~i_sys_clk;

	swpmc_host_model host (.i_sys_clk(i_sys_clk), .i_rd_data(rdat), .o_addr(addr),
		.o_wr_data(wdat), .o_wr_stb(wstb), .o_rd_stb(rstb));

	swpmc_top #(.PORTS(2), .IDLE_UNIT_CYC(4), .PULSE_PERIOD_CYC(40)) dut (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(addr), .i_wr_data(wdat),
		.i_wr_stb(wstb), .i_rd_stb(rstb), .i_cable_energy(energy), .i_an_enable(an_en),
		.i_phy_pdn(pdn), .o_rd_data(rdat), .o_clk_gen_en(clk_en), .o_mac_en(mac_en),
		.o_host_if_en(host_en), .o_phy_tx_en(tx_en), .o_phy_rx_en(rx_en),
		.o_phy_ed_en(ed_en), .o_ed_pulse(ed_pulse), .o_internal_reset(int_rst));

	task automatic close_out;
	begin
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		host.host_read(swpmc_pkg::REG_POWER_MODE, rd);
		`CHK(rd, 8'h00);
		host.host_read(swpmc_pkg::REG_SLEEP_IDLE, rd);
		`CHK(rd, swpmc_pkg::SLEEP_IDLE_RST);
		host.host_read(8'h7f, rd);
		`CHK(rd, 8'h00);
		`CHK({clk_en, mac_en, host_en, tx_en, rx_en, ed_en}, 9'h1fc);
		// Saving: port 1 has auto-negotiation off so its receiver must stay on
		an_en <= 2'b01;
		host.host_write(swpmc_pkg::REG_POWER_MODE, 8'h18);
		repeat (4) @(posedge i_sys_clk);
		#1;
		`CHK({tx_en, rx_en}, 4'b1110);
		`CHK({clk_en, mac_en, host_en}, 3'b111);
		host.host_read(swpmc_pkg::REG_POWER_MODE, rd);
		`CHK(rd, 8'h18);
		energy <= 2'b01;
		repeat (5) @(posedge i_sys_clk);
		#1;
		`CHK(rx_en, 2'b11);
		energy <= 2'b00;
		host.host_write(swpmc_pkg::REG_POWER_MODE, 8'h00);
		repeat (5) @(posedge i_sys_clk);
		#1;
		`CHK(rx_en, 2'b11);
		// Port power-down by register bit and by PHY bit
		host.host_write(swpmc_pkg::REG_PORT_CTRL_BASE + 8'h01, 8'h08);
		repeat (3) @(posedge i_sys_clk);
		pdn <= 2'b01;
		repeat (3) @(posedge i_sys_clk);
		#1;
		`CHK({tx_en, rx_en}, 4'b0000);
		pdn <= 2'b00;
		host.host_write(swpmc_pkg::REG_PORT_CTRL_BASE + 8'h01, 8'h00);
		// Energy detect: pulse width, sleep, wake on energy
		host.host_write(swpmc_pkg::REG_SLEEP_IDLE, 8'h02);
		host.host_write(swpmc_pkg::REG_POWER_MODE, 8'h08);
		for (n = 0; n < 60 && ed_pulse !== 1'b1; n++)
		begin
			@(posedge i_sys_clk);
			#1;
		end
		for (n = 0; n < 30 && ed_pulse === 1'b1; n++)
		begin
			@(posedge i_sys_clk);
			#1;
		end
		`CHK(n, swpmc_pkg::PULSE_WIDTH_CYC);
		for (n = 0; n < 300 && clk_en !== 1'b0; n++)
			@(posedge i_sys_clk);
		#1;
		`CHK({clk_en, mac_en, host_en, tx_en, ed_en}, 7'h03);
		energy <= 2'b10;
		for (n = 0; n < 8 && clk_en !== 1'b1; n++)
			@(posedge i_sys_clk);
		#1;
		`CHK({clk_en, mac_en, host_en}, 3'b111);
		host.host_write(swpmc_pkg::REG_POWER_MODE, 8'h00);
		energy <= 2'b00;
		// Soft power-down, then a dummy access wakes and resets
		host.host_write(swpmc_pkg::REG_POWER_MODE, 8'h10);
		#1;
		`CHK(clk_en, 1'b1);
		repeat (2) @(posedge i_sys_clk);
		#1;
		`CHK({clk_en, mac_en, host_en, tx_en, rx_en}, 7'h00);
		host.host_read(swpmc_pkg::REG_STATUS, rd);
		`CHK(rd, 8'h00);
		for (n = 0; n < 6 && int_rst !== 1'b1; n++)
		begin
			@(posedge i_sys_clk);
			#1;
		end
		`CHK(int_rst, 1'b1);
		host.host_read(swpmc_pkg::REG_SLEEP_IDLE, rd);
		`CHK(rd, swpmc_pkg::SLEEP_IDLE_RST);
		host.host_read(swpmc_pkg::REG_POWER_MODE, rd);
		`CHK(rd, 8'h00);
		close_out();
	end

	// Whole run is well under 2000 cycles, so this only fires on a hang
	initial
	begin
		#200000;
		bad_count++;
		close_out();
	end
endmodule
